// ---- acec_regs.svh ----
// register offsets, field positions and reset values of the converter control block
`ifndef ACEC_REGS_SVH
`define ACEC_REGS_SVH
// byte addresses on the apb bus
`define ACEC_OFF_PCLK_EN0 12'h000
`define ACEC_OFF_CONV_MODE0 12'h004
`define ACEC_OFF_IRQ_MASK 12'h008
`define ACEC_OFF_IRQ_REQ 12'h00C
`define ACEC_OFF_PRIO_HI 12'h010
`define ACEC_OFF_PRIO_LO 12'h014
`define ACEC_OFF_PORT2_DIR 12'h018
`define ACEC_OFF_LIMITS 12'h01C
`define ACEC_OFF_MODE2 12'h020
`define ACEC_OFF_RESULT 12'h024
// field positions
`define ACEC_BIT_CLK_GATE 5
`define ACEC_BIT_CONV_RUN 7
`define ACEC_BIT_CMP_EN 0
`define ACEC_BIT_CONV_END 0
`define ACEC_BIT_PIN_DIR 0
`define ACEC_BIT_RANGE_SEL 3
`define ACEC_BIT_HW_WAIT 6
// reset values
`define ACEC_RST_PCLK_EN0 8'h00
`define ACEC_RST_CONV_MODE0 8'h00
`define ACEC_RST_MASK 8'hFF
`define ACEC_RST_PRIO 8'hFF
`define ACEC_RST_PORT2_DIR 8'hFF
`define ACEC_RST_UPPER 8'hFF
`define ACEC_RST_LOWER 8'h00
// timing: stabilisation wait and conversion length in ns at 40 ns clock
`define ACEC_CLK_NS 40
`define ACEC_STAB_NS 1000
`define ACEC_CONV_NS 4000
`define ACEC_STAB_CYC ((`ACEC_STAB_NS + `ACEC_CLK_NS - 1) / `ACEC_CLK_NS)
`define ACEC_CONV_CYC ((`ACEC_CONV_NS + `ACEC_CLK_NS - 1) / `ACEC_CLK_NS)
`endif

// ---- acec_pkg.sv ----
// types shared by the converter control block
package acec_pkg;
   // sequencer states
   typedef enum logic [1:0] {ACEC_IDLE, ACEC_STAB, ACEC_CONV} acec_state_t;
   // apb request group
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } acec_apb_req_t;
   // apb answer group
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } acec_apb_rsp_t;
endpackage

// ---- acec_top.sv ----
// converter control slice with conversion-end interrupt
`timescale 1ns/1ps
`default_nettype none
`include "acec_regs.svh"
module acec_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // apb slave
   input wire acec_pkg::acec_apb_req_t apb_req_i,
   output acec_pkg::acec_apb_rsp_t apb_rsp_o,
   // analog core side
   input wire logic conv_done_i,
   input wire logic [9:0] conversion_result_i,
   output logic conv_clk_en_o,
   output logic comparator_en_o,
   output logic conv_busy_o,
   // shared pin
   input wire logic pin_in_i,
   output logic pin_out_o,
   output logic pin_oe_o,
   output logic pin_in_sync_o,
   // interrupt
   output logic irq_o,
   output logic [1:0] irq_prio_o
);
   import acec_pkg::*;

   // register state
   // mode, limit and range registers change only while the clock gate is on
   logic [7:0] pclk_en0_q, pclk_en0_d; // peripheral clock enable 0
   logic [7:0] mode0_q, mode0_d; // converter mode 0
   logic [7:0] mask_q, mask_d; // interrupt mask 1 high
   logic [7:0] req_q, req_d; // interrupt request 1 high
   logic [7:0] prhi_q, prhi_d; // priority upper bit register
   logic [7:0] prlo_q, prlo_d; // priority lower bit register
   logic [7:0] pdir_q, pdir_d; // port 2 direction
   logic [7:0] pout_q, pout_d; // port 2 output latch
   logic [7:0] upper_q, upper_d; // result upper limit
   logic [7:0] lower_q, lower_d; // result lower limit
   logic [7:0] mode2_q, mode2_d; // range select and trigger wait
   logic [9:0] result_q, result_d; // last conversion result
   acec_apb_rsp_t rsp_q, rsp_d; // registered bus answer
   // sequencer state
   acec_state_t st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   // synchronisers
   logic [1:0] done_sync_q;
   // edge detect resets low, the idle level of the done line, so no false edge
   logic done_prev_q;
   logic [1:0] pin_sync_q;
   // outputs
   logic irq_q, busy_q;

   // decode helpers
   logic wr_acc, rd_acc, gate_on, done_evt, in_range, raise;
   logic [7:0] wbyte;
   // registers are one byte wide; upper write bits matter only for paired words
   assign wbyte = apb_req_i.pwdata[7:0];
   // a write lands at the end of the access phase
   assign wr_acc = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
   // read decode in setup, so the registered answer stands in the access phase
   assign rd_acc = apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite;
   // clock gate bit, also the write lock of the converter registers
   assign gate_on = pclk_en0_q[`ACEC_BIT_CLK_GATE];
   // conversion done pulse from core, edge of synced level
   assign done_evt = done_sync_q[1] & ~done_prev_q;
   // compare upper eight result bits against limits, inclusive
   // taken straight from the core input, which is what gets captured on done
   assign in_range = (conversion_result_i[9:2] >= lower_q) &&
                     (conversion_result_i[9:2] <= upper_q);
   // only a done seen while converting may raise the flag
   // range select zero: inside window; one: outside window
   assign raise = done_evt && (st_q == ACEC_CONV) &&
                  (mode2_q[`ACEC_BIT_RANGE_SEL] ? !in_range : in_range);

   // synchronisers, first stage read only by the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_sync_q <= 2'h0;
         done_prev_q <= 1'b0;
         pin_sync_q <= 2'h0;
      end else begin
         // done line is asynchronous to this clock
         done_sync_q <= {done_sync_q[0], conv_done_i};
         done_prev_q <= done_sync_q[1];
         // pin likewise, two stages before any reader
         pin_sync_q <= {pin_sync_q[0], pin_in_i};
      end
   end

   // conversion sequencer next state
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      // gate closed or run bit cleared stops at the next edge
      if (!gate_on || !mode0_q[`ACEC_BIT_CONV_RUN]) begin
         st_d = ACEC_IDLE;
         // a leftover count is dropped, so a restart waits in full again
         cnt_d = 8'h00;
      end else begin
         case (st_q)
            ACEC_IDLE: begin
               // hardware wait mode counts power stabilisation first
               if (mode2_q[`ACEC_BIT_HW_WAIT]) begin
                  st_d = ACEC_STAB;
                  cnt_d = 8'(`ACEC_STAB_CYC);
               end else begin
                  // software trigger converts at once
                  st_d = ACEC_CONV;
               end
            end
            ACEC_STAB: begin
               // count down the power stabilisation wait, convert at one
               if (cnt_q <= 8'h01) begin
                  st_d = ACEC_CONV;
               end else begin
                  cnt_d = cnt_q - 8'h01;
               end
            end
            ACEC_CONV: begin
               st_d = ACEC_CONV; // sequential conversion until run clears
            end
            default: begin
               // unused code falls back to idle
               st_d = ACEC_IDLE;
            end
         endcase
      end
   end

   // register file next values and bus answer
   always_comb begin
      pclk_en0_d = pclk_en0_q;
      mode0_d = mode0_q;
      mask_d = mask_q;
      req_d = req_q;
      prhi_d = prhi_q;
      prlo_d = prlo_q;
      pdir_d = pdir_q;
      pout_d = pout_q;
      upper_d = upper_q;
      lower_d = lower_q;
      mode2_d = mode2_q;
      result_d = result_q;
      rsp_d = '0;
      if (done_evt && st_q == ACEC_CONV) begin
         result_d = conversion_result_i;
      end
      // software writes, converter registers only while gated on
      if (wr_acc) begin
         case (apb_req_i.paddr)
            // the gate register itself is never locked
            `ACEC_OFF_PCLK_EN0: pclk_en0_d = wbyte;
            `ACEC_OFF_CONV_MODE0: if (gate_on) mode0_d = wbyte;
            `ACEC_OFF_MODE2: if (gate_on) mode2_d = wbyte;
            `ACEC_OFF_LIMITS: begin
               if (gate_on) begin
                  lower_d = wbyte;
                  upper_d = apb_req_i.pwdata[15:8];
               end
            end
            // interrupt and port registers sit outside the converter lock
            `ACEC_OFF_IRQ_MASK: mask_d = wbyte;
            `ACEC_OFF_IRQ_REQ: req_d = req_q & wbyte;
            `ACEC_OFF_PRIO_HI: prhi_d = wbyte;
            `ACEC_OFF_PRIO_LO: prlo_d = wbyte;
            `ACEC_OFF_PORT2_DIR: begin
               pdir_d = wbyte;
               pout_d = apb_req_i.pwdata[15:8];
            end
            default: begin
               // unmapped or read-only word: the write is dropped
               rsp_d.pslverr = 1'b0;
            end
         endcase
      end
      // hardware set wins over a same-cycle software clear
      if (raise) begin
         req_d[`ACEC_BIT_CONV_END] = 1'b1;
      end
      // reads: answer valid in access phase, one wait-free cycle
      if (apb_req_i.psel & ~apb_req_i.penable) begin
         rsp_d.pready = 1'b1;
         case (apb_req_i.paddr)
            `ACEC_OFF_PCLK_EN0: rsp_d.prdata = {24'h000000, pclk_en0_q};
            `ACEC_OFF_CONV_MODE0: begin
               // run bit reads live activity, not the stored request
               rsp_d.prdata = {24'h000000, (st_q != ACEC_IDLE), mode0_q[6:0]};
            end
            `ACEC_OFF_IRQ_MASK: rsp_d.prdata = {24'h000000, mask_q};
            `ACEC_OFF_IRQ_REQ: rsp_d.prdata = {24'h000000, req_q};
            `ACEC_OFF_PRIO_HI: rsp_d.prdata = {24'h000000, prhi_q};
            `ACEC_OFF_PRIO_LO: rsp_d.prdata = {24'h000000, prlo_q};
            `ACEC_OFF_PORT2_DIR: rsp_d.prdata = {16'h0000, pout_q, pdir_q};
            `ACEC_OFF_LIMITS: rsp_d.prdata = {16'h0000, upper_q, lower_q};
            `ACEC_OFF_MODE2: rsp_d.prdata = {24'h000000, mode2_q};
            `ACEC_OFF_RESULT: rsp_d.prdata = {22'h000000, result_q};
            default: begin
               // an unmapped word answers with an error and zero data
               rsp_d.pslverr = rd_acc | apb_req_i.pwrite; // unmapped address
            end
         endcase
      end
   end

   // state registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pclk_en0_q <= `ACEC_RST_PCLK_EN0;
         mode0_q <= `ACEC_RST_CONV_MODE0;
         // interrupt comes up masked at the lowest level
         mask_q <= `ACEC_RST_MASK;
         req_q <= 8'h00;
         prhi_q <= `ACEC_RST_PRIO;
         prlo_q <= `ACEC_RST_PRIO;
         // pin comes up as input, its buffer off
         pdir_q <= `ACEC_RST_PORT2_DIR;
         pout_q <= 8'h00;
         upper_q <= `ACEC_RST_UPPER;
         lower_q <= `ACEC_RST_LOWER;
         mode2_q <= 8'h00;
         result_q <= 10'h000;
         rsp_q <= '0;
         st_q <= ACEC_IDLE;
         cnt_q <= 8'h00;
      end else begin
         pclk_en0_q <= pclk_en0_d;
         mode0_q <= mode0_d;
         mask_q <= mask_d;
         req_q <= req_d;
         prhi_q <= prhi_d;
         prlo_q <= prlo_d;
         pdir_q <= pdir_d;
         pout_q <= pout_d;
         upper_q <= upper_d;
         lower_q <= lower_d;
         mode2_q <= mode2_d;
         result_q <= result_d;
         rsp_q <= rsp_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // next values of the pin, gate and interrupt outputs
   logic clk_en_d, cmp_en_d, pin_out_d, pin_oe_d, irq_d, busy_d; // output flop inputs
   logic [1:0] prio_d; // priority code, 00 is the most urgent
   always_comb begin
      // the analog clock follows the gate bit alone
      clk_en_d = gate_on;
      // comparator stays off while the gate is closed, whatever its bit says
      cmp_en_d = gate_on & mode0_q[`ACEC_BIT_CMP_EN];
      pin_out_d = pout_q[`ACEC_BIT_PIN_DIR]; // latch value, only seen while driving
      // direction zero drives the pin, one leaves it to the analog input
      pin_oe_d = ~pdir_q[`ACEC_BIT_PIN_DIR];
      // level interrupt, held off by the mask while the flag stays pending
      irq_d = req_q[`ACEC_BIT_CONV_END] & ~mask_q[`ACEC_BIT_CONV_END];
      // upper bit from one register, lower bit from the other
      prio_d = {prhi_q[`ACEC_BIT_CONV_END], prlo_q[`ACEC_BIT_CONV_END]};
      // busy covers the stabilisation wait as well as conversion
      busy_d = (st_q != ACEC_IDLE);
   end

   // registered outputs, one flop each so nothing leaves through logic
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_clk_en_o <= 1'b0;
         comparator_en_o <= 1'b0;
         pin_out_o <= 1'b0;
         pin_oe_o <= 1'b0;
         pin_in_sync_o <= 1'b0;
         irq_q <= 1'b0;
         busy_q <= 1'b0;
         irq_prio_o <= 2'h3;
      end else begin
         conv_clk_en_o <= clk_en_d;
         comparator_en_o <= cmp_en_d;
         pin_out_o <= pin_out_d;
         pin_oe_o <= pin_oe_d;
         pin_in_sync_o <= pin_sync_q[1];
         irq_q <= irq_d;
         busy_q <= busy_d;
         irq_prio_o <= prio_d;
      end
   end

   // bus answer and the two outputs kept in internal flops
   assign apb_rsp_o = rsp_q;
   assign irq_o = irq_q;
   assign conv_busy_o = busy_q;
endmodule
`default_nettype wire

// ---- acec_top_chk.sv ----
// assertion checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "acec_regs.svh"
module acec_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // watched ports
   input wire acec_pkg::acec_apb_req_t apb_req_i,
   input wire acec_pkg::acec_apb_rsp_t apb_rsp_o,
   input wire logic conv_clk_en_o,
   input wire logic comparator_en_o,
   input wire logic conv_busy_o,
   input wire logic pin_oe_o,
   input wire logic irq_o,
   input wire logic [1:0] irq_prio_o
);
   import acec_pkg::*;
   // completed write with its address and data
   logic wr;
   logic [11:0] a;
   logic [31:0] d;
   assign wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & apb_rsp_o.pready;
   assign a = apb_req_i.paddr;
   assign d = apb_req_i.pwdata;
   // one domain, so clock and reset are given once
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   gate_write_a: assert property (
      wr && a == `ACEC_OFF_PCLK_EN0 |-> ##2 conv_clk_en_o == $past(d[5], 2))
      else $error("clock gate not applied");
   gate_refuse_a: assert property (
      !conv_clk_en_o && wr && a == `ACEC_OFF_CONV_MODE0 |-> ##2 !conv_busy_o && !comparator_en_o)
      else $error("write taken while clock gated");
   run_stop_a: assert property (
      wr && a == `ACEC_OFF_CONV_MODE0 && !d[7] |-> ##3 !conv_busy_o)
      else $error("conversion not halted");
   cmp_follow_a: assert property (
      wr && a == `ACEC_OFF_CONV_MODE0 && conv_clk_en_o |-> ##2 comparator_en_o == $past(d[0], 2))
      else $error("comparator enable wrong");
   mask_block_a: assert property (
      wr && a == `ACEC_OFF_IRQ_MASK && d[0] |-> ##2 !irq_o)
      else $error("masked interrupt seen");
   flag_clear_a: assert property (
      wr && a == `ACEC_OFF_IRQ_REQ && !d[0] && !conv_busy_o |-> ##2 !irq_o)
      else $error("request flag not cleared");
   prio_high_a: assert property (
      wr && a == `ACEC_OFF_PRIO_HI |-> ##2 irq_prio_o[1] == $past(d[0], 2))
      else $error("priority bit wrong");
   pin_dir_a: assert property (
      wr && a == `ACEC_OFF_PORT2_DIR |-> ##2 pin_oe_o != $past(d[0], 2))
      else $error("pin drive wrong");
   // main scenarios reached
   cover property (irq_o);
   cover property (conv_busy_o);
   cover property (apb_rsp_o.pslverr);
endmodule
bind acec_top acec_chk acec_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(apb_req_i),
   .apb_rsp_o(apb_rsp_o), .conv_clk_en_o(conv_clk_en_o), .comparator_en_o(comparator_en_o),
   .conv_busy_o(conv_busy_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o), .irq_prio_o(irq_prio_o));
`default_nettype wire

// ---- test_adc_control_and_end_interrupt.sv ----
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "acec_regs.svh"
module test_adc_control_and_end_interrupt;
   import acec_pkg::*;
   // stimulus and observed signals
   logic clk_i = 0, rst_n_i = 0, done = 0, pin = 1;
   logic [9:0] res = '0;
   acec_apb_req_t req = '0;
   acec_apb_rsp_t rsp;
   logic clk_en, cmp_en, busy, p_out, p_oe, p_sync, irq, er;
   logic [1:0] prio;
   logic [31:0] rd;
   int err_total = 0, checks_done = 0, cyc = 0;
   // write rows: address, data, expected read-back
   localparam logic [11:0] RA [8] = '{`ACEC_OFF_PCLK_EN0, `ACEC_OFF_IRQ_MASK,
      `ACEC_OFF_PRIO_HI, `ACEC_OFF_PRIO_LO, `ACEC_OFF_PORT2_DIR, `ACEC_OFF_LIMITS,
      `ACEC_OFF_MODE2, `ACEC_OFF_CONV_MODE0};
   localparam logic [31:0] RW [8] = '{32'h20, 32'h0, 32'h0, 32'h1, 32'h100, 32'h8040, 32'h0, 32'h1};
   // conversion rows: result and interrupt expected (window 0x40..0x80)
   localparam logic [9:0] CV [5] = '{10'h180, 10'h200, 10'h100, 10'h0FC, 10'h204};
   localparam logic CE [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   always #20 clk_i = ~clk_i;
   acec_top acec_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
      .conv_done_i(done), .conversion_result_i(res), .conv_clk_en_o(clk_en),
      .comparator_en_o(cmp_en), .conv_busy_o(busy), .pin_in_i(pin), .pin_out_o(p_out),
      .pin_oe_o(p_oe), .pin_in_sync_o(p_sync), .irq_o(irq), .irq_prio_o(prio));
   // counts, verdict, end of run
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one compare for every value
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // apb transfer held until pready; trailing edges let outputs settle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_i);
      req.penable <= 1'b1;
      // no wait-state count assumed; only the bench timeout ends a hang
      do begin
         @(posedge clk_i);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   // one conversion, its interrupt masked, unmasked and cleared
   task automatic conv(input logic [9:0] r, input logic e);
      apb(1, `ACEC_OFF_CONV_MODE0, 32'h01);
      apb(1, `ACEC_OFF_CONV_MODE0, 32'h81);
      apb(0, `ACEC_OFF_CONV_MODE0, 0);
      chk("run", 32'h81, rd & 32'hFF);
      res <= r;
      done <= 1'b1;
      repeat (8) @(posedge clk_i);
      done <= 1'b0;
      chk("irq", e, irq);
      apb(0, `ACEC_OFF_IRQ_REQ, 0);
      chk("flag", e, rd & 32'h1);
      apb(1, `ACEC_OFF_IRQ_MASK, 1);
      chk("masked", 0, irq);
      apb(1, `ACEC_OFF_IRQ_MASK, 0);
      chk("unmasked", e, irq);
      apb(1, `ACEC_OFF_IRQ_REQ, 0);
      chk("cleared", 0, irq);
   endtask
   // hang guard, run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         report_and_stop();
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         apb(1, RA[i], RW[i]);
         apb(0, RA[i], 0);
         chk("readback", RW[i], rd & 32'hFFFF);
      end
      chk("prio", 1, prio);
      chk("pin", 3'b111, {p_oe, p_out, p_sync});
      chk("gates", 2'b11, {clk_en, cmp_en});
      // pin input seen through two sync stages and the output flop
      pin <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("pin sync", 0, p_sync);
      for (int i = 0; i < 5; i++) conv(CV[i], CE[i]);
      // range select one: only results outside the window interrupt
      apb(1, `ACEC_OFF_CONV_MODE0, 32'h00);
      apb(1, `ACEC_OFF_MODE2, 32'h08);
      conv(10'h0FC, 1'b1);
      conv(10'h180, 1'b0);
      // hardware wait mode: run reads one through the stabilisation wait
      apb(1, `ACEC_OFF_CONV_MODE0, 32'h00);
      apb(1, `ACEC_OFF_MODE2, 32'h40);
      apb(1, `ACEC_OFF_CONV_MODE0, 32'h81);
      apb(0, `ACEC_OFF_CONV_MODE0, 0);
      chk("wait run", 32'h81, rd & 32'hFF);
      chk("wait busy", 1, busy);
      // a done during the wait is not a conversion end
      res <= 10'h180;
      done <= 1'b1;
      repeat (8) @(posedge clk_i);
      done <= 1'b0;
      chk("wait irq", 0, irq);
      // wait over, the next done converts and lands in the window
      repeat (20) @(posedge clk_i);
      done <= 1'b1;
      repeat (8) @(posedge clk_i);
      done <= 1'b0;
      chk("conv irq", 1, irq);
      apb(1, `ACEC_OFF_CONV_MODE0, 32'h01);
      chk("stopped", 0, busy);
      // stopping leaves the request pending until software clears it
      chk("still pending", 1, irq);
      apb(1, `ACEC_OFF_IRQ_REQ, 32'hFE);
      chk("idle clear", 0, irq);
      apb(0, 12'h030, 0);
      chk("unmapped", 1, er);
      // second reset in mid-run, then defaults and gated writes
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 1; i < 5; i++) begin
         apb(0, RA[i], 0);
         chk("reset", 32'hFF, rd & 32'hFF);
      end
      chk("reset out", 3'b110, {prio, p_oe});
      apb(1, `ACEC_OFF_CONV_MODE0, 32'h81);
      apb(0, `ACEC_OFF_CONV_MODE0, 0);
      chk("gated", 0, {rd[7:0], clk_en, cmp_en, busy});
      report_and_stop();
   end
endmodule
`default_nettype wire
